/* bench/auto_sleep_wake_controller_test.sv */
/*
 Self-checking bench for the sleep/wake controller, one task per scenario.
 Assumes short step parameters (20 and 40 cycles) and a 10 MHz clock.
*/
`timescale 1ns/1ns
module auto_sleep_wake_controller_test;
    import sleep_ctrl_pkg::*;
    logic ref_clk, rst, wbCyc, wbStb, wbWe, wbAck, otherIrqFirst, otherIrqSecond, fifoEmpty;
    logic asleep, fifoBlocked, irqPinFirst, irqPinSecond, irq;
    logic [9:0] wbAdr, eventPulse, eventEnableEff;
    logic [3:0] wbSel;
    logic [31:0] wbDatIn, wbDatOut, d;
    logic [2:0] rateCode;
    int n_mismatch = 0;
    int check_count = 0;
    // Bus master and device
    host_model host (.ref_clk(ref_clk), .wbAck(wbAck), .wbDatOut(wbDatOut), .wbCyc(wbCyc), .wbStb(wbStb),
        .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn));
    auto_sleep_wake_controller #(.STEP_SHORT(20), .STEP_LONG(40)) uut (.ref_clk(ref_clk), .rst(rst),
        .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn),
        .wbDatOut(wbDatOut), .wbAck(wbAck), .eventPulse(eventPulse), .otherIrqFirst(otherIrqFirst),
        .otherIrqSecond(otherIrqSecond), .fifoEmpty(fifoEmpty), .asleep(asleep), .rateCode(rateCode),
        .fifoBlocked(fifoBlocked), .eventEnableEff(eventEnableEff), .irqPinFirst(irqPinFirst),
        .irqPinSecond(irqPinSecond), .irq(irq));
    // Clock, 100 ns period
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // Comparison and bus helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] dummy;
        host.xfer(1'b1, idx, wd, dummy);
    endtask
    task automatic rd(input logic [7:0] idx);
        host.xfer(1'b0, idx, 32'h0, d);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic pulse(input logic [9:0] ev);
        @(posedge ref_clk);
        eventPulse <= ev;
        @(posedge ref_clk);
        eventPulse <= 10'h000;
    endtask
    task automatic wait_sleep(input logic v, input int maxc);
        int i;
        i = 0;
        while (asleep !== v && i < maxc) begin
            cyc(1);
            i++;
        end
    endtask
    // Programs the count before enabling sleep
    task automatic arm(input logic [31:0] cnt, input logic [31:0] one, input logic [31:0] two);
        wr(IDX_SLEEP_COUNT, cnt);
        wr(IDX_CTRL_ONE, one);
        wr(IDX_CTRL_TWO, two);
    endtask
    task automatic disarm;
        wr(IDX_CTRL_TWO, 32'h0);
        wr(IDX_IRQ_STATUS, 32'h7);
        rd(IDX_SYS_MODE);
        cyc(1);
        chk(32'(irq), 32'h0);
    endtask
    // Scenarios
    task automatic t_regs;
        rd(IDX_SLEEP_COUNT);
        chk(d, 32'h0);
        wr(IDX_SLEEP_COUNT, 32'hA5);
        rd(IDX_SLEEP_COUNT);
        chk(d, 32'hA5);
        rd(8'h40);
        chk(d, 32'h0);
    endtask
    task automatic t_entry;
        wr(IDX_FUNC_EN, 32'h3FF);
        wr(IDX_WAKE_CFG, 32'h5FE);
        wr(IDX_IRQ_MASK, 32'h7);
        wr(IDX_INT_ROUTE, 32'h1);
        arm(32'h2, 32'h11, 32'h1);
        cyc(35);
        chk(32'(asleep), 32'h0);
        wait_sleep(1'b1, 15);
        chk(32'(asleep), 32'h1);
        chk(32'(rateCode), 32'h6);
        cyc(2);
        chk(32'(irqPinFirst), 32'h1);
        chk(32'(irqPinSecond), 32'h0);
        chk(32'(irq), 32'h1);
        rd(IDX_SYS_MODE);
        chk(d & 32'h3, 32'h2);
        cyc(2);
        chk(32'(irqPinFirst), 32'h0);
        @(posedge ref_clk);
        otherIrqFirst <= 1'b1;
        otherIrqSecond <= 1'b1;
        cyc(2);
        chk(32'(irqPinFirst), 32'h1);
        chk(32'(irqPinSecond), 32'h1);
        @(posedge ref_clk);
        otherIrqFirst <= 1'b0;
        otherIrqSecond <= 1'b0;
    endtask
    task automatic t_wake;
        pulse(10'h001);
        cyc(3);
        chk(32'(asleep), 32'h1);
        wr(IDX_FUNC_EN, 32'h3F7);
        pulse(10'h008);
        cyc(3);
        chk(32'(asleep), 32'h1);
        pulse(10'h020);
        cyc(2);
        chk(32'(asleep), 32'h0);
        chk(32'(rateCode), 32'h1);
        cyc(2);
        chk(32'(irqPinFirst), 32'h1);
        pulse(10'h008);
        disarm();
        wr(IDX_FUNC_EN, 32'h3FF);
    endtask
    task automatic t_restart;
        arm(32'h2, 32'h11, 32'h1);
        cyc(30);
        pulse(10'h010);
        cyc(30);
        chk(32'(asleep), 32'h0);
        wait_sleep(1'b1, 20);
        chk(32'(asleep), 32'h1);
        disarm();
        arm(32'h2, 32'h11, 32'h1);
        cyc(30);
        pulse(10'h200);
        wait_sleep(1'b1, 15);
        chk(32'(asleep), 32'h1);
        disarm();
    endtask
    task automatic t_step(input logic [31:0] one, input logic [31:0] two);
        arm(32'h1, one, two);
        cyc(30);
        chk(32'(asleep), 32'h0);
        wait_sleep(1'b1, 20);
        chk(32'(asleep), 32'h1);
        disarm();
    endtask
    task automatic t_bypass;
        wr(IDX_SLEEP_BYPASS, 32'h204);
        arm(32'h1, 32'h11, 32'h1);
        wait_sleep(1'b1, 40);
        cyc(2);
        chk(32'(eventEnableEff), 32'h1FB);
        pulse(10'h002);
        cyc(3);
        chk(32'(asleep), 32'h0);
        chk(32'(eventEnableEff), 32'h1FF);
        wr(IDX_FUNC_EN, 32'h3FF);
        cyc(2);
        chk(32'(eventEnableEff), 32'h3FF);
        disarm();
        wr(IDX_SLEEP_BYPASS, 32'h0);
    endtask
    task automatic t_gate;
        fifoEmpty <= 1'b0;
        wr(IDX_INT_ROUTE, 32'h0);
        wr(IDX_WAKE_CFG, 32'h5FF);
        arm(32'h1, 32'h11, 32'h1);
        wait_sleep(1'b1, 40);
        cyc(2);
        chk(32'(fifoBlocked), 32'h1);
        chk(32'(irqPinSecond), 32'h1);
        chk(32'(irqPinFirst), 32'h0);
        rd(IDX_SYS_MODE);
        chk(d & 32'h83, 32'h82);
        fifoEmpty <= 1'b1;
        cyc(3);
        chk(32'(fifoBlocked), 32'h0);
        @(posedge ref_clk);
        fifoEmpty <= 1'b0;
        pulse(10'h002);
        cyc(3);
        chk(32'(asleep), 32'h0);
        chk(32'(fifoBlocked), 32'h1);
        @(posedge ref_clk);
        fifoEmpty <= 1'b1;
        disarm();
    endtask
    // Verdict and end of run
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        $display("FAIL %0t watchdog expired", $time);
        report_and_stop();
    end
    // Main sequence
    initial begin
        rst = 1'b1;
        eventPulse = 10'h000;
        otherIrqFirst = 1'b0;
        otherIrqSecond = 1'b0;
        fifoEmpty = 1'b1;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        t_entry();
        t_wake();
        t_restart();
        t_step(32'h11, 32'h3);
        t_step(32'h17, 32'h1);
        t_bypass();
        t_gate();
        report_and_stop();
    end
endmodule // auto_sleep_wake_controller_test

/* bench/host_model.sv */
/*
 Host side model: issues classic Wishbone single cycles for the bench.
 Assumes the slave answers with a registered ack on ref_clk.
*/
`timescale 1ns/1ns
module host_model (
    input wire logic ref_clk,
    input wire logic wbAck,
    input wire logic [31:0] wbDatOut,
    output logic wbCyc,
    output logic wbStb,
    output logic wbWe,
    output logic [9:0] wbAdr,
    output logic [3:0] wbSel,
    output logic [31:0] wbDatIn
);
    // Idle bus from time zero
    initial begin
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        wbAdr <= 10'h000;
        wbSel <= 4'h0;
        wbDatIn <= 32'h0;
    end
    // One cycle held until ack, then released with scrambled lines
    task automatic xfer(input logic we, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rdata);
        @(posedge ref_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= {idx, 2'b00};
        wbSel <= 4'hF;
        wbDatIn <= wd;
        do @(posedge ref_clk); while (wbAck !== 1'b1);
        rdata = wbDatOut;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        wbAdr <= ~{idx, 2'b00};
        wbDatIn <= ~wd;
    endtask
endmodule // host_model

/* hdl/auto_sleep_wake_controller.sv */
/*
 Inactivity-driven auto-sleep and wake controller with a classic Wishbone
 register slave, sticky interrupt status, routing to two interrupt pins and
 FIFO gating. Event inputs are one-cycle pulses from logic on ref_clk; the
 FIFO empty level also comes from ref_clk logic.
*/
// Chosen here: the Wishbone register port.
`timescale 1ns/1ns
module auto_sleep_wake_controller #(
    parameter int STEP_SHORT = sleep_ctrl_pkg::STEP_SHORT_CYCLES,
    parameter int STEP_LONG = sleep_ctrl_pkg::STEP_LONG_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [9:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatIn,
    output logic [31:0] wbDatOut,
    output logic wbAck,
    input wire logic [sleep_ctrl_pkg::NUM_EVENTS-1:0] eventPulse,
    input wire logic otherIrqFirst,
    input wire logic otherIrqSecond,
    input wire logic fifoEmpty,
    output logic asleep,
    output logic [2:0] rateCode,
    output logic fifoBlocked,
    output logic [sleep_ctrl_pkg::NUM_EVENTS-1:0] eventEnableEff,
    output logic irqPinFirst,
    output logic irqPinSecond,
    output logic irq
);
    import sleep_ctrl_pkg::*;

    // Software state
    logic [7:0] sleepCount, next_sleepCount;
    logic [4:0] ctrlOne, next_ctrlOne;
    logic [1:0] ctrlTwo, next_ctrlTwo;
    logic [10:0] wakeCfg, next_wakeCfg;
    logic [9:0] funcEn, next_funcEn;
    logic [0:0] intRoute, next_intRoute;
    logic [9:0] sleepBypass, next_sleepBypass;
    logic [2:0] irqStatus, next_irqStatus;
    logic [2:0] irqMask, next_irqMask;
    // Block state
    logic [PRESCALE_W-1:0] prescale, next_prescale;
    logic [7:0] inactCnt, next_inactCnt;
    logic swIrq, next_swIrq;
    logic fgerr, next_fgerr;
    logic readyHeld, next_readyHeld;
    logic next_asleep, next_fifoBlocked, next_wbAck, next_irq;
    logic next_irqPinFirst, next_irqPinSecond;
    logic [2:0] next_rateCode;
    logic [31:0] next_wbDatOut;
    logic [9:0] next_eventEnableEff;
    // Decoded terms
    logic access, doWrite, doRead, restart, wakeHit, stepLong, stepDone;
    logic expired, enterSleep, leaveSleep, transition;
    logic [7:0] idx;
    logic [31:0] wdat, regNow;
    sys_mode_t modeNow;

    // Bus decode, one access per handshake
    assign access = wbCyc && wbStb && !wbAck;
    assign doWrite = access && wbWe;
    assign doRead = access && !wbWe;
    assign idx = wbAdr[9:2];
    assign modeNow = asleep ? MODE_SLEEP : MODE_WAKE;

    // Byte-lane merge helper
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = dat[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Event qualification
    always_comb begin
        // R5 restart sources
        // R7 enabled sources only
        restart = |(eventPulse[EV_FIELD_THRESH:EV_FIFO] & funcEn[EV_FIELD_THRESH:EV_FIFO]);
        // R6 wake sources
        wakeHit = |(eventPulse[EV_FIELD_THRESH:1] & funcEn[EV_FIELD_THRESH:1] & wakeCfg[EV_FIELD_THRESH:1]);
        // R3 long step at slowest rate
        // R4 hybrid halves the rate
        stepLong = (ctrlOne[2:0] == RATE_SLOWEST) || ctrlTwo[F_HYBRID];
        // R2 short step otherwise
        stepDone = stepLong ? (prescale == PRESCALE_W'(STEP_LONG - 1)) : (prescale == PRESCALE_W'(STEP_SHORT - 1));
        // R1 sleep after the programmed inactivity
        expired = inactCnt >= sleepCount;
        enterSleep = !asleep && ctrlTwo[F_SLEEP_ENABLE] && !restart && expired;
        leaveSleep = asleep && (wakeHit || !ctrlTwo[F_SLEEP_ENABLE]);
        transition = enterSleep || leaveSleep;
    end

    // Register file next values
    always_comb begin
        wdat = merge(regNow, wbDatIn, wbSel);
        next_sleepCount = sleepCount;
        next_ctrlOne = ctrlOne;
        next_ctrlTwo = ctrlTwo;
        next_wakeCfg = wakeCfg;
        next_funcEn = funcEn;
        next_intRoute = intRoute;
        next_sleepBypass = sleepBypass;
        next_irqMask = irqMask;
        next_irqStatus = irqStatus;
        next_readyHeld = readyHeld;
        if (doWrite) begin
            unique case (idx)
                // R13 inactivity count register
                IDX_SLEEP_COUNT: next_sleepCount = wdat[7:0];
                IDX_CTRL_ONE: next_ctrlOne = wdat[4:0];
                IDX_CTRL_TWO: next_ctrlTwo = wdat[1:0];
                IDX_WAKE_CFG: next_wakeCfg = wdat[10:0];
                IDX_FUNC_EN: begin
                    next_funcEn = wdat[9:0];
                    next_readyHeld = 1'b0;
                end
                IDX_INT_ROUTE: next_intRoute = wdat[0:0];
                IDX_SLEEP_BYPASS: next_sleepBypass = wdat[9:0];
                IDX_IRQ_MASK: next_irqMask = wdat[2:0];
                // Write one to clear, low byte lane only
                IDX_IRQ_STATUS: next_irqStatus = irqStatus & ~(wbDatIn[2:0] & {3{wbSel[0]}});
                default: ;
            endcase
        end
        // Events set status, set wins over clear
        if (enterSleep) begin
            next_irqStatus[ST_SLEEP_ENTRY] = 1'b1;
        end
        if (leaveSleep) begin
            next_irqStatus[ST_WAKE] = 1'b1;
        end
        if (enterSleep && wakeCfg[F_FIFO_GATE]) begin
            next_irqStatus[ST_FIFO_GATE] = 1'b1;
        end
        // R9 sample ready stays off after a bypassed sleep
        if (enterSleep && sleepBypass[EV_SAMPLE_READY]) begin
            next_readyHeld = 1'b1;
        end
    end

    // Sleep sequencing next values
    always_comb begin
        next_prescale = prescale;
        next_inactCnt = inactCnt;
        next_asleep = asleep;
        if (asleep || !ctrlTwo[F_SLEEP_ENABLE] || restart || transition) begin
            // R8 restart aborts and zeroes the count
            // R15 clear on entry and wake
            next_prescale = '0;
            next_inactCnt = 8'h00;
        end else if (stepDone) begin
            // R15 one count per step
            next_prescale = '0;
            next_inactCnt = (inactCnt == 8'hFF) ? inactCnt : inactCnt + 8'h01;
        end else begin
            next_prescale = prescale + PRESCALE_W'(1);
        end
        if (enterSleep) begin
            next_asleep = 1'b1;
        end else if (leaveSleep) begin
            // R6 back to the active rate
            next_asleep = 1'b0;
        end
        // R1 rate selection follows the mode
        next_rateCode = next_asleep ? (RATE_SLEEP_BASE | {1'b0, ctrlOne[F_SLEEP_RATE_LSB +: 2]}) : ctrlOne[2:0];
        // R9 bypassed flags masked while asleep
        next_eventEnableEff = funcEn & ~(next_asleep ? sleepBypass : ZERO_EVENTS);
        if (next_readyHeld) begin
            next_eventEnableEff[EV_SAMPLE_READY] = 1'b0;
        end
    end

    // Sleep/wake flag, FIFO gate and pins next values
    always_comb begin
        next_swIrq = swIrq;
        next_fgerr = fgerr;
        next_fifoBlocked = fifoBlocked;
        // R10 reading mode register clears
        if (doRead && idx == IDX_SYS_MODE) begin
            next_swIrq = 1'b0;
        end
        // R10 every transition raises it
        if (transition && wakeCfg[F_SW_IRQ_EN]) begin
            next_swIrq = 1'b1;
        end
        if (fifoEmpty) begin
            next_fifoBlocked = 1'b0;
            next_fgerr = 1'b0;
        end
        // R11 gate on sleep entry
        if (enterSleep && wakeCfg[F_FIFO_GATE]) begin
            next_fgerr = 1'b1;
            next_fifoBlocked = 1'b1;
        end
        // R12 interrupt stalls FIFO, not transitions
        if (next_swIrq && !swIrq && wakeCfg[F_FIFO_GATE]) begin
            next_fifoBlocked = 1'b1;
        end
        // R14 route to one pin, ORed with others
        next_irqPinFirst = otherIrqFirst || (next_swIrq && intRoute[F_ROUTE_SW]);
        next_irqPinSecond = otherIrqSecond || (next_swIrq && !intRoute[F_ROUTE_SW]);
        next_irq = |(next_irqStatus & next_irqMask);
    end

    // Bus answer next values, read mux shared with the write merge
    always_comb begin
        next_wbAck = access;
        unique case (idx)
            IDX_SYS_MODE: regNow = {24'h00_0000, fgerr, 5'h00, modeNow};
            IDX_SLEEP_COUNT: regNow = 32'(sleepCount);
            IDX_CTRL_ONE: regNow = 32'(ctrlOne);
            IDX_CTRL_TWO: regNow = 32'(ctrlTwo);
            IDX_WAKE_CFG: regNow = 32'(wakeCfg);
            IDX_FUNC_EN: regNow = 32'(funcEn);
            IDX_INT_ROUTE: regNow = 32'(intRoute);
            IDX_SLEEP_BYPASS: regNow = 32'(sleepBypass);
            IDX_IRQ_STATUS: regNow = 32'(irqStatus);
            IDX_IRQ_MASK: regNow = 32'(irqMask);
            default: regNow = 32'h0000_0000;
        endcase
        next_wbDatOut = doRead ? regNow : 32'h0000_0000;
    end

    // State registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sleepCount <= SLEEP_COUNT_RST;
            ctrlOne <= 5'h00;
            ctrlTwo <= 2'h0;
            wakeCfg <= 11'h000;
            funcEn <= 10'h000;
            intRoute <= 1'b0;
            sleepBypass <= 10'h000;
            irqStatus <= 3'h0;
            irqMask <= 3'h0;
            readyHeld <= 1'b0;
            prescale <= '0;
            inactCnt <= 8'h00;
            asleep <= 1'b0;
            rateCode <= 3'h0;
            eventEnableEff <= 10'h000;
            swIrq <= 1'b0;
            fgerr <= 1'b0;
            fifoBlocked <= 1'b0;
            irqPinFirst <= 1'b0;
            irqPinSecond <= 1'b0;
            irq <= 1'b0;
            wbAck <= 1'b0;
            wbDatOut <= 32'h0000_0000;
        end else begin
            sleepCount <= next_sleepCount;
            ctrlOne <= next_ctrlOne;
            ctrlTwo <= next_ctrlTwo;
            wakeCfg <= next_wakeCfg;
            funcEn <= next_funcEn;
            intRoute <= next_intRoute;
            sleepBypass <= next_sleepBypass;
            irqStatus <= next_irqStatus;
            irqMask <= next_irqMask;
            readyHeld <= next_readyHeld;
            prescale <= next_prescale;
            inactCnt <= next_inactCnt;
            asleep <= next_asleep;
            rateCode <= next_rateCode;
            eventEnableEff <= next_eventEnableEff;
            swIrq <= next_swIrq;
            fgerr <= next_fgerr;
            fifoBlocked <= next_fifoBlocked;
            irqPinFirst <= next_irqPinFirst;
            irqPinSecond <= next_irqPinSecond;
            irq <= next_irq;
            wbAck <= next_wbAck;
            wbDatOut <= next_wbDatOut;
        end
    end

    // Checks
    a_restart_zeroes_count: assert property (@(posedge ref_clk) disable iff (rst) // R8
        (!asleep && restart) |=> (inactCnt == 8'h00 && prescale == '0))
        else $error("restart did not clear the inactivity counter");
    a_sleep_on_expiry: assert property (@(posedge ref_clk) disable iff (rst) // R1
        (!asleep && ctrlTwo[F_SLEEP_ENABLE] && !restart && inactCnt >= sleepCount) |=> asleep)
        else $error("no sleep entry after inactivity expired");
    a_no_early_sleep: assert property (@(posedge ref_clk) disable iff (rst) // R1
        $rose(asleep) |-> ($past(inactCnt) >= $past(sleepCount)))
        else $error("sleep entered before count reached");
    a_wake_on_enabled: assert property (@(posedge ref_clk) disable iff (rst) // R6
        (asleep && |(eventPulse[8:1] & funcEn[8:1] & wakeCfg[8:1])) |=> (!asleep && rateCode == ctrlOne[2:0]))
        else $error("enabled wake source did not wake");
    a_fifo_no_wake: assert property (@(posedge ref_clk) disable iff (rst) // R6
        (asleep && ctrlTwo[F_SLEEP_ENABLE] && eventPulse == 10'h001) |=> asleep)
        else $error("fifo event woke the device");
    a_disabled_ignored: assert property (@(posedge ref_clk) disable iff (rst) // R7
        (!asleep && ctrlTwo[F_SLEEP_ENABLE] && |eventPulse[EV_FIELD_THRESH:EV_FIFO]
        && (eventPulse[EV_FIELD_THRESH:EV_FIFO] & funcEn[EV_FIELD_THRESH:EV_FIFO]) == 9'h000
        && inactCnt < sleepCount && !stepDone)
        |=> (inactCnt == $past(inactCnt) && prescale == $past(prescale) + PRESCALE_W'(1)))
        else $error("disabled event touched the count");
    a_transition_irq: assert property (@(posedge ref_clk) disable iff (rst) // R10
        ($changed(asleep) && wakeCfg[F_SW_IRQ_EN] && $past(wakeCfg[F_SW_IRQ_EN])) |-> swIrq)
        else $error("transition did not raise the sleep/wake interrupt");
    a_gate_on_entry: assert property (@(posedge ref_clk) disable iff (rst) // R11
        (enterSleep && wakeCfg[F_FIFO_GATE] && !fifoEmpty) |=> (fgerr && fifoBlocked) ##1 (fifoBlocked || fifoEmpty))
        else $error("fifo gate not applied on sleep entry");
    a_route_pins: assert property (@(posedge ref_clk) disable iff (rst) // R14
        (swIrq && !$past(otherIrqFirst) && !$past(otherIrqSecond) && $stable(intRoute)) |->
        (irqPinFirst == intRoute[0] && irqPinSecond == !intRoute[0]))
        else $error("sleep/wake interrupt on the wrong pin");
    a_ack_single: assert property (@(posedge ref_clk) disable iff (rst)
        wbAck |=> !wbAck)
        else $error("ack held for more than one cycle");
endmodule // auto_sleep_wake_controller

/* hdl/sleep_ctrl_pkg.sv */
/*
 Constants for the inactivity sleep/wake controller: register indices, field
 positions, reset values, event numbering and step timing.
 Assumes a 10 MHz reference clock and a 32-bit classic Wishbone register bus.
*/
// Function
// R1 - With sleep enabled, drop from the active rate to the sleep rate after the programmed inactivity time.
// R2 - For rates from 800 Hz down to 6.25 Hz one count unit is 320 ms, about 81 s at most.
// R3 - At 1.56 Hz one count unit is 640 ms, one sample period, about 163 s at most.
// R4 - In hybrid mode the step follows half the selected rate, so 800 Hz gives a 640 ms step.
// R5 - FIFO, transient, orientation, tap, freefall, magnetic and the three magnitude/threshold events restart the count.
// R6 - While asleep any wake-capable source enabled in the wake configuration returns to the active rate.
// R7 - A source affects restart, sleep or wake only when its function is enabled.
// R8 - A restart source before the count is reached aborts sleep entry and zeroes the counter.
// R9 - Flags of bypassed functions are masked while asleep and come back on wake, except sample ready.
// R10 - With the sleep/wake interrupt enabled every transition raises it, and reading the mode register clears it.
// R11 - With FIFO gating, sleep entry keeps the FIFO, sets the gate error flag and blocks samples until emptied.
// R12 - With FIFO gating, the sleep/wake interrupt blocks the FIFO until flushed instead of blocking transitions.
// R13 - The inactivity count is an 8-bit read/write register at index 0x29, reset to zero, set by the host.
// R14 - The sleep/wake interrupt goes to the first pin when its routing bit is 1, else the second, ORed with others.
// R15 - The inactivity counter advances once per step while awake and clears on sleep entry and on wake.
package sleep_ctrl_pkg;
    // Timing
    localparam int CLK_KHZ = 10_000;
    localparam int STEP_SHORT_MS = 320;
    localparam int STEP_LONG_MS = 640;
    localparam int STEP_SHORT_CYCLES = STEP_SHORT_MS * CLK_KHZ;
    localparam int STEP_LONG_CYCLES = STEP_LONG_MS * CLK_KHZ;
    localparam int PRESCALE_W = 24;
    // Register indices, byte address is four times the index
    localparam logic [7:0] IDX_SYS_MODE = 8'h0B;
    localparam logic [7:0] IDX_SLEEP_COUNT = 8'h29;
    localparam logic [7:0] IDX_CTRL_ONE = 8'h2A;
    localparam logic [7:0] IDX_CTRL_TWO = 8'h2B;
    localparam logic [7:0] IDX_WAKE_CFG = 8'h2C;
    localparam logic [7:0] IDX_FUNC_EN = 8'h2D;
    localparam logic [7:0] IDX_INT_ROUTE = 8'h2E;
    localparam logic [7:0] IDX_SLEEP_BYPASS = 8'h2F;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h31;
    // Event numbering, bits 1..8 are wake capable
    localparam int NUM_EVENTS = 10;
    localparam int EV_FIFO = 0;
    localparam int EV_FIELD_THRESH = 8;
    localparam int EV_SAMPLE_READY = 9;
    // Field positions
    localparam int F_ACTIVE_RATE_LSB = 0;
    localparam int F_SLEEP_RATE_LSB = 3;
    localparam int F_SLEEP_ENABLE = 0;
    localparam int F_HYBRID = 1;
    localparam int F_FIFO_GATE = 0;
    localparam int F_SW_IRQ_EN = 10;
    localparam int F_ROUTE_SW = 0;
    localparam int F_FGERR = 7;
    localparam int ST_SLEEP_ENTRY = 0;
    localparam int ST_WAKE = 1;
    localparam int ST_FIFO_GATE = 2;
    // Rate code of the slowest rate, 1.56 Hz
    localparam logic [2:0] RATE_SLOWEST = 3'h7;
    localparam logic [2:0] RATE_SLEEP_BASE = 3'h4;
    // Reset values
    localparam logic [7:0] SLEEP_COUNT_RST = 8'h00;
    localparam logic [9:0] ZERO_EVENTS = 10'h000;
    typedef enum logic [1:0] {MODE_STANDBY = 2'b00, MODE_WAKE = 2'b01, MODE_SLEEP = 2'b10} sys_mode_t;
endpackage
